/* File: hw/ocpc_defs.svh */
// Register map, field positions, reset values and timing figures
`ifndef OCPC_DEFS_SVH
`define OCPC_DEFS_SVH
`define OCPC_IDX_DRIVE 8'h63
`define OCPC_IDX_PHASE 8'h64
`define OCPC_RST_DRIVE 8'h01
`define OCPC_RST_PHASE 8'h03
`define OCPC_DRV_LOAD 3
`define OCPC_DRV_IMODE_HI 2
`define OCPC_DRV_IMODE_LO 0
`define OCPC_DRV_FCB_HI 7
`define OCPC_DRV_FCB_LO 4
`define OCPC_PH_EN 7
`define OCPC_PH_SEL_HI 6
`define OCPC_PH_SEL_LO 4
`define OCPC_PH_FCB_HI 3
`define OCPC_PH_FCB_LO 0
`define OCPC_PH_STEPS_LOG2 3
`define OCPC_PH_NONE 3'h0
`define OCPC_TAP_BITS 6
`define OCPC_TAP_MAX 6'h3F
`define OCPC_HTRANS_NONSEQ_BIT 1
`define OCPC_HRESP_OKAY 1'h0
`endif

/* File: hw/ocpc_pkg.sv */
// Types shared by the output clock phase control block
`default_nettype none
package ocpc_pkg;
   typedef logic [7:0] ocpc_byte_t;
   typedef logic [11:0] ocpc_word_t;
   typedef logic [2:0] ocpc_phase_t;
   typedef logic [5:0] ocpc_tap_t;
   typedef logic [2:0] ocpc_drive_t;
   typedef enum logic [1:0]
   {
      OCPC_PAT_A = 2'h1,
      OCPC_PAT_B = 2'h2
   } ocpc_pat_t;
endpackage
`default_nettype wire

/* File: hw/ocpc_phase_delay.sv */
// Tapped delay line that shifts the sampled clock by a cycle count
`timescale 1ns/1ps
`default_nettype none
`include "ocpc_defs.svh"
module ocpc_phase_delay
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic din,
   input wire ocpc_pkg::ocpc_tap_t tap,
   output var logic dout
);
   import ocpc_pkg::*;
   logic [63:0] line;

   // Delay line
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         line <= 64'h0;
      else
         line <= {line[62:0], din};
   end

   // Tap select
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         dout <= 1'h0;
      else if (tap == 6'h0)
         dout <= din;
      else
         dout <= line[tap - 6'h1];
   end
endmodule // ocpc_phase_delay
`default_nettype wire

/* File: hw/ocpc_top.sv */
// Output clock phase control with AHB-Lite configuration registers
//
// What this block does and what its software must do
// [RULE1] Custom pattern mode: alternate words A and B onto outputs; bit 11 over-range, bit 10 word clock.
// [RULE2] Phase delay applied only with enable set and decimation on; reset keeps default.
// [RULE3] Phase code selects shift of code times 45 degrees, 000 none to 111 +315.
// [RULE4] Software uses odd shifts only when separate clocking settings permit them.
// [RULE5] Every nonzero shift is added on top of the default phase reference.
// [RULE6] Phase field steers the output clock only in decimation operation.
// [RULE7] Software must not program reserved drive current codes.
// [RULE8] Software leaves factory bits at reset values.
// [RULE9] Fields read back as written; reset loads printed defaults.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ocpc_defs.svh"
module ocpc_top
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output var logic [31:0] hrdata,
   output var logic hreadyout,
   output var logic hresp,
   input wire logic base_clock,
   input wire logic decimation_active,
   input wire logic custom_pattern_mode,
   input wire ocpc_pkg::ocpc_word_t custom_pattern_a,
   input wire ocpc_pkg::ocpc_word_t custom_pattern_b,
   input wire ocpc_pkg::ocpc_word_t sample_data,
   input wire logic sample_over_range,
   input wire logic sample_word_clock,
   output var logic output_data_clock,
   output var logic [9:0] q_data,
   output var logic over_range_flag,
   output var logic word_clock_output,
   output var ocpc_pkg::ocpc_drive_t drive_current_select,
   output var logic lvds_load_enable,
   output var logic phase_delay_enable,
   output var ocpc_pkg::ocpc_phase_t decimated_phase_select
);
   import ocpc_pkg::*;

   function automatic logic [31:0] byte_addr(input logic [7:0] idx);
      byte_addr = {22'h0, idx, 2'h0};
   endfunction

   function automatic ocpc_tap_t phase_tap(input ocpc_phase_t code, input ocpc_tap_t period);
      logic [8:0] prod;
      prod = 9'(code) * 9'(period);
      phase_tap = prod[`OCPC_PH_STEPS_LOG2 +: `OCPC_TAP_BITS];
   endfunction

   ocpc_byte_t lvds_output_drive_config;
   ocpc_byte_t decimated_clock_phase_config;
   logic wr_pend;
   logic [31:0] wr_addr;
   logic clk_s1;
   logic clk_s2;
   logic clk_s3;
   logic clk_rise;
   ocpc_tap_t period_cnt;
   ocpc_tap_t period;
   ocpc_tap_t tap;
   ocpc_tap_t next_tap;
   logic delayed_clock;
   ocpc_pat_t pat_sel;

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'h0;
         wr_addr <= 32'h0;
      end
      else if (hready)
      begin
         wr_pend <= hsel && htrans[`OCPC_HTRANS_NONSEQ_BIT] && hwrite;
         wr_addr <= haddr;
      end
   end

   // Register writes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lvds_output_drive_config <= `OCPC_RST_DRIVE; // RULE9
         decimated_clock_phase_config <= `OCPC_RST_PHASE; // RULE9
      end
      else if (wr_pend)
      begin
         if (wr_addr == byte_addr(`OCPC_IDX_DRIVE))
            lvds_output_drive_config <= hwdata[7:0]; // RULE9
         else if (wr_addr == byte_addr(`OCPC_IDX_PHASE))
            decimated_clock_phase_config <= hwdata[7:0]; // RULE9
      end
   end

   // Read data, ready and response
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h0;
         hreadyout <= 1'h1;
         hresp <= `OCPC_HRESP_OKAY;
      end
      else
      begin
         hreadyout <= 1'h1;
         hresp <= `OCPC_HRESP_OKAY;
         if (hready && hsel && htrans[`OCPC_HTRANS_NONSEQ_BIT] && !hwrite)
         begin
            if (haddr == byte_addr(`OCPC_IDX_DRIVE))
               hrdata <= {24'h0, lvds_output_drive_config}; // RULE9
            else if (haddr == byte_addr(`OCPC_IDX_PHASE))
               hrdata <= {24'h0, decimated_clock_phase_config}; // RULE9
            else
               hrdata <= 32'h0;
         end
      end
   end

   // Field outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         drive_current_select <= 3'h0;
         lvds_load_enable <= 1'h0;
         phase_delay_enable <= 1'h0;
         decimated_phase_select <= 3'h0;
      end
      else
      begin
         drive_current_select <= lvds_output_drive_config[`OCPC_DRV_IMODE_HI:`OCPC_DRV_IMODE_LO];
         lvds_load_enable <= lvds_output_drive_config[`OCPC_DRV_LOAD];
         phase_delay_enable <= decimated_clock_phase_config[`OCPC_PH_EN];
         decimated_phase_select <= decimated_clock_phase_config[`OCPC_PH_SEL_HI:`OCPC_PH_SEL_LO];
      end
   end

   // Base clock synchroniser and edge finder
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clk_s1 <= 1'h0;
         clk_s2 <= 1'h0;
         clk_s3 <= 1'h0;
      end
      else
      begin
         clk_s1 <= base_clock;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
      end
   end

   assign clk_rise = clk_s2 && !clk_s3;

   // Base clock period in hclk cycles
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         period_cnt <= 6'h0;
         period <= 6'h0;
      end
      else if (clk_rise)
      begin
         period_cnt <= 6'h0;
         period <= (period_cnt == `OCPC_TAP_MAX) ? `OCPC_TAP_MAX : period_cnt + 6'h1;
      end
      else if (period_cnt != `OCPC_TAP_MAX)
         period_cnt <= period_cnt + 6'h1;
   end

   // Shift in eighths of a period over the default phase
   always_comb
   begin
      next_tap = 6'h0; // RULE5
      if (decimation_active && decimated_clock_phase_config[`OCPC_PH_EN]) // RULE2 RULE6
         next_tap = phase_tap(decimated_clock_phase_config[`OCPC_PH_SEL_HI:`OCPC_PH_SEL_LO], period); // RULE3 RULE5
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         tap <= 6'h0;
      else
         tap <= next_tap;
   end

   ocpc_phase_delay u_delay
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .din(clk_s2),
      .tap(tap),
      .dout(delayed_clock)
   );

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         output_data_clock <= 1'h0;
      else
         output_data_clock <= delayed_clock;
   end

   // Pattern word alternation
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pat_sel <= OCPC_PAT_A;
      else if (!custom_pattern_mode)
         pat_sel <= OCPC_PAT_A;
      else if (clk_rise)
      begin
         case (pat_sel)
            OCPC_PAT_A: pat_sel <= OCPC_PAT_B; // RULE1
            OCPC_PAT_B: pat_sel <= OCPC_PAT_A; // RULE1
            default: pat_sel <= OCPC_PAT_A;
         endcase
      end
   end

   // Output data bits
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q_data <= 10'h0;
         over_range_flag <= 1'h0;
         word_clock_output <= 1'h0;
      end
      else if (custom_pattern_mode && pat_sel == OCPC_PAT_B)
      begin
         q_data <= custom_pattern_b[9:0]; // RULE1
         over_range_flag <= custom_pattern_b[11]; // RULE1
         word_clock_output <= custom_pattern_b[10]; // RULE1
      end
      else if (custom_pattern_mode)
      begin
         q_data <= custom_pattern_a[9:0]; // RULE1
         over_range_flag <= custom_pattern_a[11]; // RULE1
         word_clock_output <= custom_pattern_a[10]; // RULE1
      end
      else
      begin
         q_data <= sample_data[9:0];
         over_range_flag <= sample_over_range;
         word_clock_output <= sample_word_clock;
      end
   end
endmodule // ocpc_top
`default_nettype wire

/* File: verif/ocpc_checker.sv */
// Port assertions for the output clock phase control block
`timescale 1ns/1ps
`default_nettype none
module ocpc_checker
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic custom_pattern_mode,
   input wire ocpc_pkg::ocpc_word_t custom_pattern_a,
   input wire logic [9:0] q_data,
   input wire logic over_range_flag,
   input wire logic word_clock_output,
   input wire ocpc_pkg::ocpc_drive_t drive_current_select,
   input wire logic lvds_load_enable,
   input wire logic phase_delay_enable,
   input wire ocpc_pkg::ocpc_phase_t decimated_phase_select
);
   import ocpc_pkg::*;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready okay");
   a_read_high_zero: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_reset_fields: assert property ($rose(hresetn) |=> drive_current_select == 3'h1
      && !phase_delay_enable && decimated_phase_select == 3'h0 && !lvds_load_enable) else $error("bad reset fields");
   a_phase_write: assert property (hsel && hready && htrans[1] && hwrite && haddr == 32'h190
      |=> ##2 {phase_delay_enable, decimated_phase_select} == $past(hwdata[7:4], 2)) else $error("phase field");
   a_drive_write: assert property (hsel && hready && htrans[1] && hwrite && haddr == 32'h18C
      |=> ##2 {lvds_load_enable, drive_current_select} == $past(hwdata[3:0], 2)) else $error("drive field");
   a_pattern_start: assert property ($rose(custom_pattern_mode)
      |=> {over_range_flag, word_clock_output, q_data} == custom_pattern_a) else $error("first word not A");
endmodule // ocpc_checker
bind ocpc_top ocpc_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .custom_pattern_mode(custom_pattern_mode), .custom_pattern_a(custom_pattern_a), .q_data(q_data),
   .over_range_flag(over_range_flag), .word_clock_output(word_clock_output), .lvds_load_enable(lvds_load_enable),
   .drive_current_select(drive_current_select), .phase_delay_enable(phase_delay_enable),
   .decimated_phase_select(decimated_phase_select));
`default_nettype wire

/* File: verif/ocpc_rx_model.sv */
// Receiver model capturing output words on the output data clock
`timescale 1ns/1ps
`default_nettype none
module ocpc_rx_model
(
   input wire logic output_data_clock,
   input wire logic [9:0] q_data,
   input wire logic over_range_flag,
   input wire logic word_clock_output,
   output logic [11:0] rx_word
);
   always @(posedge output_data_clock)
   begin
      #2 rx_word = {over_range_flag, word_clock_output, q_data};
   end
endmodule // ocpc_rx_model
`default_nettype wire

/* File: verif/ocpc_top_tb.sv */
// Register, phase and pattern tests for the output clock phase control block
`timescale 1ns/1ps
`default_nettype none
module ocpc_top_tb;
   import ocpc_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, base_clock, decimation_active, custom_pattern_mode;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [9:0] q_data;
   logic output_data_clock, over_range_flag, word_clock_output, lvds_load_enable, phase_delay_enable;
   ocpc_word_t pat_a, pat_b, rx_word, w;
   ocpc_drive_t drive_current_select;
   ocpc_phase_t decimated_phase_select;
   ocpc_drive_t codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
   int fails = 0, comparisons = 0, cycles = 0, d0, n;
   ocpc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .base_clock(base_clock), .decimation_active(decimation_active), .custom_pattern_mode(custom_pattern_mode),
      .custom_pattern_a(pat_a), .custom_pattern_b(pat_b), .sample_data(12'h155), .sample_over_range(1'b0),
      .sample_word_clock(1'b1), .output_data_clock(output_data_clock), .q_data(q_data),
      .over_range_flag(over_range_flag), .word_clock_output(word_clock_output),
      .drive_current_select(drive_current_select), .lvds_load_enable(lvds_load_enable),
      .phase_delay_enable(phase_delay_enable), .decimated_phase_select(decimated_phase_select));
   ocpc_rx_model u_rx (.output_data_clock(output_data_clock), .q_data(q_data), .over_range_flag(over_range_flag),
      .word_clock_output(word_clock_output), .rx_word(rx_word));
   always #10 hclk = ~hclk;
   task automatic give_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge hclk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         fails = fails + 1;
         give_verdict;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One single bus transfer, entered just after a rising edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
   // Cycles from a link clock rise to the next output clock rise
   task automatic meas(output int m);
      logic prev;
      repeat (40) @(posedge hclk);
      @(posedge base_clock);
      prev = output_data_clock;
      m = 0;
      do
      begin
         @(posedge hclk);
         m = m + 1;
         if (output_data_clock === 1'b1 && prev === 1'b0)
            break;
         prev = output_data_clock;
      end while (m < 16);
   endtask
   initial
   begin
      hclk = 0;
      hresetn = 0;
      hsel = 0;
      haddr = 0;
      htrans = 0;
      hwrite = 0;
      hwdata = 0;
      decimation_active = 0;
      custom_pattern_mode = 0;
      pat_a = 12'hA5C;
      pat_b = 12'h7C3;
      base_clock = 0;
      fork
         begin
            #7;
            forever #80 base_clock = ~base_clock;
         end
      join_none
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(0, 32'h18C, 0, rd);
      check(rd, 32'h01);
      bus(0, 32'h190, 0, rd);
      check(rd, 32'h03);
      bus(1, 32'h0, 32'hFF, rd);
      bus(0, 32'h0, 0, rd);
      check(rd, 32'h0);
      foreach (codes[i])
      begin
         bus(1, 32'h18C, {28'h0, 1'b1, codes[i]}, rd);
         bus(0, 32'h18C, 0, rd);
         check(rd, {28'h0, 1'b1, codes[i]});
         check(drive_current_select, codes[i]);
         check(lvds_load_enable, 1'b1);
      end
      meas(d0);
      decimation_active <= 1'b1;
      for (int c = 0; c < 8; c++)
      begin
         bus(1, 32'h190, {24'h0, 1'b1, 3'(c), 4'h3}, rd);
         meas(n);
         // Rise launched on the edge before the link rise is missed, so the count wraps into 2..9
         check(n, (d0 + c - 2) % 8 + 2);
         check({phase_delay_enable, decimated_phase_select}, {1'b1, 3'(c)});
      end
      decimation_active <= 1'b0;
      meas(n);
      check(n, d0);
      decimation_active <= 1'b1;
      bus(1, 32'h190, 32'h53, rd);
      meas(n);
      check(n, d0);
      custom_pattern_mode <= 1'b1;
      repeat (40) @(posedge hclk);
      check(rx_word === pat_a || rx_word === pat_b, 1);
      // Two captures in a row carry both words
      @(posedge output_data_clock);
      #5 w = rx_word;
      @(posedge output_data_clock);
      @(posedge hclk);
      check({w, rx_word} === {pat_a, pat_b} || {w, rx_word} === {pat_b, pat_a}, 1);
      custom_pattern_mode <= 1'b0;
      repeat (4) @(posedge hclk);
      check({over_range_flag, word_clock_output, q_data}, 12'h555);
      give_verdict;
   end
endmodule // ocpc_top_tb
`default_nettype wire
